// file: rtl/dtrig_pkg.sv
// Package for the external trigger and timing logic
package dtrig_pkg;

   // Register indices on the plain register port
   localparam logic [3:0] DTRIG_REG_CTRL      = 4'h0;
   localparam logic [3:0] DTRIG_REG_STROBE    = 4'h1;
   localparam logic [3:0] DTRIG_REG_STATUS    = 4'h2;
   localparam logic [3:0] DTRIG_REG_IRQ_CLR   = 4'h3;
   localparam logic [3:0] DTRIG_REG_IRQ_EN    = 4'h4;
   localparam logic [3:0] DTRIG_REG_CONV_CNT  = 4'h5;

   // Control register fields
   localparam int DTRIG_CTRL_ARM_BIT     = 0;
   localparam int DTRIG_CTRL_PRETRIG_BIT = 1;
   localparam int DTRIG_CTRL_SCAN_BIT    = 2;
   localparam int DTRIG_CTRL_TMRSEL_BIT  = 3;
   localparam int DTRIG_CTRL_TMRIRQ_BIT  = 4;
   localparam int DTRIG_CTRL_SWCONV_BIT  = 5;
   localparam logic [5:0] DTRIG_CTRL_RESET = 6'h00;

   // Interrupt status fields
   localparam int DTRIG_IRQ_TIMED_BIT = 0;
   localparam int DTRIG_IRQ_START_BIT = 1;
   localparam int DTRIG_IRQ_POST_BIT  = 2;
   localparam int DTRIG_IRQ_CONV_BIT  = 3;
   localparam int DTRIG_IRQ_W         = 4;
   localparam logic [3:0] DTRIG_IRQ_RESET = 4'h0;

   // Timing
   localparam int DTRIG_CLK_MHZ         = 40;
   localparam int DTRIG_STROBE_MIN_NS   = 500;
   localparam int DTRIG_STROBE_CYCLES   = (DTRIG_STROBE_MIN_NS * DTRIG_CLK_MHZ + 999) / 1000;
   localparam int DTRIG_SCAN_HIGH_NS    = 100;
   localparam int DTRIG_SCAN_CYCLES     = (DTRIG_SCAN_HIGH_NS * DTRIG_CLK_MHZ + 999) / 1000;
   localparam int DTRIG_CNT_W           = 8;

   // Acquisition sequence states, Gray along the path
   typedef enum logic [1:0] {
      DTRIG_IDLE = 2'b00,
      DTRIG_WAIT = 2'b01,
      DTRIG_PRE  = 2'b11,
      DTRIG_POST = 2'b10
   } dtrig_state_t;

   // Register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } dtrig_req_t;

   // Synchronised connector inputs, active low
   typedef struct packed {
      logic trig_n;
      logic gate_n;
      logic conv_n;
      logic tmr_n;
   } dtrig_pins_t;

endpackage

// file: rtl/dtrig_sync_edge.sv
// Two-stage synchroniser with falling-edge detect
`timescale 1ns/1ps
module dtrig_sync_edge
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Pin and results
   input  wire logic pin_in,
   output logic      level,
   output logic      fall
);
   logic meta;
   logic sync;
   logic prev;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= 1'b1;
         sync <= 1'b1;
         prev <= 1'b1;
      end
      else
      begin
         meta <= pin_in;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level = sync;
   assign fall  = prev & ~sync;
endmodule

// file: rtl/dtrig_top.sv
// External trigger, gate, convert, strobe and scan clock logic
// Operation
// - One scan pulse per conversion when scanning
// - Scan rising edge marks input release
// - Strobe write gives low pulse >=500 ns
// - Trigger falling edge starts posttrigger acquisition
// - Pretrigger: first edge pre, second post
// - Gate low blocks, high allows conversions
// - Convert falling edge does one conversion
// - Ignore converts outside sequence or gated
// - Selected timer edge loads posted DAC values
// - Timer edge raises timed interrupt if enabled
`timescale 1ns/1ps
module dtrig_top
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // Connector inputs
   input  wire logic        acq_trigger_in_n,
   input  wire logic        conv_gate_in_n,
   input  wire logic        conv_request_in_n,
   input  wire logic        dac_update_trigger_in_n,
   // Connector outputs
   output logic             scan_pulse_out,
   output logic             strobe_pulse_out_n,
   // Converter side
   output logic             adc_convert,
   output logic             dac_load,
   output logic             pre_active,
   output logic             post_active,
   output logic             irq
);
   dtrig_pkg::dtrig_req_t   req;
   dtrig_pkg::dtrig_pins_t  lvl;
   dtrig_pkg::dtrig_pins_t  fall;
   dtrig_pkg::dtrig_state_t state;
   dtrig_pkg::dtrig_state_t next_state;

   logic [5:0]  ctrl;
   logic [3:0]  irq_stat;
   logic [3:0]  irq_en;
   logic [3:0]  irq_evt;
   logic [7:0]  conv_cnt;
   logic [5:0]  strobe_cnt;
   logic [5:0]  scan_cnt;
   logic        conv_ok;
   logic        conv_fire;
   logic        sw_conv;
   logic        post_start;
   logic        in_seq;
   logic        gate_open;

   // Control bits
   logic        arm;
   logic        pretrig_en;
   logic        scan_en;
   logic        tmr_sel;
   logic        tmr_irq_en;

   // Write decodes
   logic        wr_ctrl;
   logic        wr_strobe;
   logic        wr_irq_clr;
   logic        wr_irq_en;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Write decodes of the register port
   assign wr_ctrl    = req.wr && req.addr == dtrig_pkg::DTRIG_REG_CTRL;
   assign wr_strobe  = req.wr && req.addr == dtrig_pkg::DTRIG_REG_STROBE;
   assign wr_irq_clr = req.wr && req.addr == dtrig_pkg::DTRIG_REG_IRQ_CLR;
   assign wr_irq_en  = req.wr && req.addr == dtrig_pkg::DTRIG_REG_IRQ_EN;

   // Input synchronisers
   dtrig_sync_edge u_trig (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   (acq_trigger_in_n),
      .level    (lvl.trig_n),
      .fall     (fall.trig_n)
   );
   dtrig_sync_edge u_gate (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   (conv_gate_in_n),
      .level    (lvl.gate_n),
      .fall     (fall.gate_n)
   );
   dtrig_sync_edge u_conv (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   (conv_request_in_n),
      .level    (lvl.conv_n),
      .fall     (fall.conv_n)
   );
   dtrig_sync_edge u_tmr (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   (dac_update_trigger_in_n),
      .level    (lvl.tmr_n),
      .fall     (fall.tmr_n)
   );

   // Control register; software convert lasts one cycle, so one write is one conversion
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl <= dtrig_pkg::DTRIG_CTRL_RESET;
      else if (wr_ctrl)
         ctrl <= req.wdata[5:0];
      else
         ctrl[dtrig_pkg::DTRIG_CTRL_SWCONV_BIT] <= 1'b0;
   end

   // Named control bits
   assign arm        = ctrl[dtrig_pkg::DTRIG_CTRL_ARM_BIT];
   assign pretrig_en = ctrl[dtrig_pkg::DTRIG_CTRL_PRETRIG_BIT];
   assign scan_en    = ctrl[dtrig_pkg::DTRIG_CTRL_SCAN_BIT];
   assign tmr_sel    = ctrl[dtrig_pkg::DTRIG_CTRL_TMRSEL_BIT];
   assign tmr_irq_en = ctrl[dtrig_pkg::DTRIG_CTRL_TMRIRQ_BIT];
   assign sw_conv    = ctrl[dtrig_pkg::DTRIG_CTRL_SWCONV_BIT];

   // Acquisition sequence
   always_comb
   begin
      next_state = state;
      unique case (state)
         dtrig_pkg::DTRIG_IDLE:
            if (arm)
               next_state = dtrig_pkg::DTRIG_WAIT;
         dtrig_pkg::DTRIG_WAIT:
            if (!arm)
               next_state = dtrig_pkg::DTRIG_IDLE;
            else if (fall.trig_n && pretrig_en)
               next_state = dtrig_pkg::DTRIG_PRE;
            else if (fall.trig_n)
               next_state = dtrig_pkg::DTRIG_POST;
         dtrig_pkg::DTRIG_PRE:
            if (!arm)
               next_state = dtrig_pkg::DTRIG_IDLE;
            else if (fall.trig_n)
               next_state = dtrig_pkg::DTRIG_POST;
         dtrig_pkg::DTRIG_POST:
            if (!arm)
               next_state = dtrig_pkg::DTRIG_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= dtrig_pkg::DTRIG_IDLE;
      else
         state <= next_state;
   end

   assign pre_active  = (state == dtrig_pkg::DTRIG_PRE);
   assign post_active = (state == dtrig_pkg::DTRIG_POST);
   assign post_start  = fall.trig_n && next_state == dtrig_pkg::DTRIG_POST
                        && state != dtrig_pkg::DTRIG_POST;

   // Conversions only in a sequence and with the gate high
   assign in_seq    = pre_active || post_active;
   assign gate_open = lvl.gate_n;
   assign conv_ok   = in_seq && gate_open;
   assign conv_fire = conv_ok && (fall.conv_n || sw_conv);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         adc_convert <= 1'b0;
      else
         adc_convert <= conv_fire;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         conv_cnt <= 8'h00;
      else if (wr_ctrl)
         conv_cnt <= 8'h00;
      else if (conv_fire)
         conv_cnt <= conv_cnt + 8'h01;
   end

   // Scan clock: low during sampling, rises when input may be released
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         scan_cnt <= 6'h00;
      else if (conv_fire && scan_en)
         scan_cnt <= 6'(dtrig_pkg::DTRIG_SCAN_CYCLES);
      else if (scan_cnt != 6'h00)
         scan_cnt <= scan_cnt - 6'h01;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         scan_pulse_out <= 1'b0;
      else
         scan_pulse_out <= (scan_cnt == 6'h01);
   end

   // Strobe pulse, held low for the minimum width
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         strobe_cnt <= 6'h00;
      else if (wr_strobe)
         strobe_cnt <= 6'(dtrig_pkg::DTRIG_STROBE_CYCLES);
      else if (strobe_cnt != 6'h00)
         strobe_cnt <= strobe_cnt - 6'h01;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         strobe_pulse_out_n <= 1'b1;
      else
         strobe_pulse_out_n <= ~(wr_strobe
                                 || strobe_cnt > 6'h01);
   end

   // Timer trigger updates posted DAC values
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         dac_load <= 1'b0;
      else
         dac_load <= fall.tmr_n && tmr_sel;
   end

   // Interrupt events
   always_comb
   begin
      irq_evt = 4'h0;
      irq_evt[dtrig_pkg::DTRIG_IRQ_TIMED_BIT] = fall.tmr_n
                                   && tmr_irq_en;
      irq_evt[dtrig_pkg::DTRIG_IRQ_START_BIT] = fall.trig_n
                                   && state == dtrig_pkg::DTRIG_WAIT
                                   && arm;
      irq_evt[dtrig_pkg::DTRIG_IRQ_POST_BIT]  = post_start;
      irq_evt[dtrig_pkg::DTRIG_IRQ_CONV_BIT]  = conv_fire;
   end

   // Sticky status, set wins over clear
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat <= dtrig_pkg::DTRIG_IRQ_RESET;
      else if (wr_irq_clr)
         irq_stat <= (irq_stat & ~req.wdata[3:0]) | irq_evt;
      else
         irq_stat <= irq_stat | irq_evt;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_en <= dtrig_pkg::DTRIG_IRQ_RESET;
      else if (wr_irq_en)
         irq_en <= req.wdata[3:0];
   end

   assign irq = |(irq_stat & irq_en);

   // Read data, valid the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 32'h0000_0000;
      else if (req.rd)
      begin
         unique case (req.addr)
            dtrig_pkg::DTRIG_REG_CTRL:
               reg_rdata <= {26'h000_0000, ctrl};
            dtrig_pkg::DTRIG_REG_STROBE:
               reg_rdata <= 32'h0000_0000;
            dtrig_pkg::DTRIG_REG_STATUS:
               reg_rdata <= {24'h00_0000, lvl, 2'b00, state};
            dtrig_pkg::DTRIG_REG_IRQ_EN:
               reg_rdata <= {28'h000_0000, irq_en};
            dtrig_pkg::DTRIG_REG_IRQ_CLR:
               reg_rdata <= {28'h000_0000, irq_stat};
            dtrig_pkg::DTRIG_REG_CONV_CNT:
               reg_rdata <= {24'h00_0000, conv_cnt};
            default:
               reg_rdata <= 32'h0000_0000;
         endcase
      end
      else
         reg_rdata <= 32'h0000_0000;
   end
endmodule

// file: verif/dtrig_chk.sv
// Port checks for the trigger block
`timescale 1ns/1ps
module dtrig_chk
(
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Connector
   input wire logic        acq_trigger_in_n,
   input wire logic        dac_update_trigger_in_n,
   input wire logic        scan_pulse_out,
   input wire logic        strobe_pulse_out_n,
   // Converter side
   input wire logic        adc_convert,
   input wire logic        dac_load,
   input wire logic        pre_active,
   input wire logic        post_active
);
   logic [5:0] ctrl;
   logic [4:0] slow;
   logic       rd_q;
   logic       in_seq;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl <= 6'h00;
      else if (reg_wr && reg_addr == dtrig_pkg::DTRIG_REG_CTRL)
         ctrl <= reg_wdata[5:0];
   end
   // Cycles since the last strobe write
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         slow <= 5'h00;
      else if (reg_wr && reg_addr == dtrig_pkg::DTRIG_REG_STROBE)
         slow <= 5'h01;
      else if (slow != 5'h00 && slow != 5'h15)
         slow <= slow + 5'h01;
      else
         slow <= 5'h00;
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_q <= 1'b0;
         in_seq <= 1'b0;
      end
      else
      begin
         rd_q <= reg_rd;
         in_seq <= pre_active || post_active;
      end
   end
   sequence trig_fall;
      $fell(acq_trigger_in_n);
   endsequence
   sequence idle_seq;
      !pre_active && !post_active;
   endsequence
   sequence post_arm;
      trig_fall ##0 idle_seq ##0 ctrl[1:0] == 2'h1;
   endsequence
   sequence pre_arm;
      trig_fall ##0 idle_seq ##0 ctrl[1:0] == 2'h3;
   endsequence
   sequence tmr_fall;
      $fell(dac_update_trigger_in_n) ##0 ctrl[3];
   endsequence
   // Strobe is due low in the 20 cycles after its write
   logic strobe_due;
   assign strobe_due = slow != 5'h00 && slow <= 5'h14;
   strobe_width_a: assert property (strobe_pulse_out_n == !strobe_due)
      else $error("strobe level wrong");
   scan_follow_a: assert property (adc_convert && ctrl[2] |-> ##4 scan_pulse_out)
      else $error("scan pulse missing");
   scan_cause_a: assert property (scan_pulse_out |-> $past(adc_convert, 4))
      else $error("scan pulse without conversion");
   conv_seq_a: assert property (adc_convert |-> in_seq)
      else $error("conversion outside sequence");
   dac_follow_a: assert property (tmr_fall |-> ##[2:6] dac_load)
      else $error("dac load missing");
   post_start_a: assert property (post_arm |-> ##[2:6] post_active)
      else $error("posttrigger start missing");
   pre_start_a: assert property (pre_arm |-> ##[2:6] pre_active)
      else $error("pretrigger start missing");
   rdata_idle_a: assert property (!rd_q |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside read slot");
endmodule
bind dtrig_top dtrig_chk chk (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .acq_trigger_in_n(acq_trigger_in_n), .dac_update_trigger_in_n(dac_update_trigger_in_n),
   .scan_pulse_out(scan_pulse_out), .strobe_pulse_out_n(strobe_pulse_out_n),
   .adc_convert(adc_convert), .dac_load(dac_load), .pre_active(pre_active),
   .post_active(post_active));

// file: verif/dtrig_ext_eq.sv
// Connector-side test equipment model
`timescale 1ns/1ps
module dtrig_ext_eq
(
   // Clock
   input wire logic  core_clk,
   // Sensed output
   input wire logic  scan_pulse_out,
   // Driven pins: timer, convert, gate, trigger
   output logic [3:0] pins
);
   int n_scan = 0;
   initial pins = 4'hf;
   // Rising edge marks input release
   always @(posedge scan_pulse_out) n_scan++;
   task automatic set(input int i, input logic v);
      @(posedge core_clk);
      pins[i] <= v;
      repeat (4) @(posedge core_clk);
   endtask
   // One falling edge, then settle
   task automatic fall(input int i);
      set(i, 1'b0);
      set(i, 1'b1);
      repeat (4) @(posedge core_clk);
   endtask
endmodule

// file: verif/dtrig_top_bench.sv
// Random and corner tests of the trigger block
`timescale 1ns/1ps
module dtrig_top_bench;
   logic core_clk = 0;
   logic rst_n = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 0;
   logic reg_rd = 0;
   logic [31:0] reg_rdata;
   logic [3:0] pins;
   logic scan_pulse_out, strobe_pulse_out_n, adc_convert, dac_load, pre_active, post_active, irq;
   int bad_count = 0;
   int n_checks = 0;
   int seed = 77126;
   int n_conv = 0;
   int n_load = 0;
   int n;
   int g;
   logic [31:0] d;
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) n_conv += (adc_convert === 1'b1);
   always @(posedge core_clk) n_load += (dac_load === 1'b1);
   dtrig_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .acq_trigger_in_n(pins[0]), .conv_gate_in_n(pins[1]), .conv_request_in_n(pins[2]),
      .dac_update_trigger_in_n(pins[3]), .scan_pulse_out(scan_pulse_out),
      .strobe_pulse_out_n(strobe_pulse_out_n), .adc_convert(adc_convert),
      .dac_load(dac_load), .pre_active(pre_active), .post_active(post_active), .irq(irq));
   dtrig_ext_eq eq (.core_clk(core_clk), .scan_pulse_out(scan_pulse_out), .pins(pins));
   function automatic int strobe_cycles(input int ns, input int mhz);
      return (ns * mhz + 999) / 1000;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1;
      @(posedge core_clk);
      reg_wr <= 0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge core_clk);
      reg_rd <= 0;
      #1 v = reg_rdata;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      print_verdict;
   end
   initial
   begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1;
      #1 chk(strobe_pulse_out_n, 1);
      wr(dtrig_pkg::DTRIG_REG_STROBE, $random(seed));
      n = 0;
      repeat (40)
      begin
         n += (strobe_pulse_out_n === 1'b0);
         @(posedge core_clk);
         #1;
      end
      chk(n, strobe_cycles(500, 40));
      chk(strobe_pulse_out_n, 1);
      eq.fall(2);
      chk(n_conv, 0);
      rd(4'hf, d);
      chk(d, 0);
      $display("end strobe and idle");
      wr(dtrig_pkg::DTRIG_REG_CTRL, 32'h0000_0005);
      eq.fall(0);
      chk(post_active, 1);
      n = 0;
      for (int i = 0; i < 8; i++)
      begin
         g = (i < 2) ? i : ($random(seed) & 1);
         eq.set(1, g[0]);
         eq.fall(2);
         n += g;
      end
      eq.set(1, 1'b1);
      rd(dtrig_pkg::DTRIG_REG_CONV_CNT, d);
      chk(d, n);
      chk(n_conv, n);
      chk(eq.n_scan, n);
      // Software convert in the sequence: exactly one conversion and one scan pulse
      wr(dtrig_pkg::DTRIG_REG_CTRL, 32'h0000_0025);
      repeat (8) @(posedge core_clk);
      rd(dtrig_pkg::DTRIG_REG_CONV_CNT, d);
      chk(d, 1);
      chk(n_conv, n + 1);
      chk(eq.n_scan, n + 1);
      $display("end posttrigger");
      wr(dtrig_pkg::DTRIG_REG_CTRL, 32'h0000_0000);
      wr(dtrig_pkg::DTRIG_REG_CTRL, 32'h0000_0003);
      eq.fall(0);
      chk(pre_active, 1);
      eq.fall(0);
      chk(post_active, 1);
      $display("end pretrigger");
      wr(dtrig_pkg::DTRIG_REG_CTRL, 32'h0000_0018);
      eq.fall(3);
      chk(n_load, 1);
      chk(irq, 0);
      rd(dtrig_pkg::DTRIG_REG_IRQ_CLR, d);
      chk(d[0], 1);
      wr(dtrig_pkg::DTRIG_REG_IRQ_EN, 32'h0000_0001);
      chk(irq, 1);
      wr(dtrig_pkg::DTRIG_REG_IRQ_CLR, 32'h0000_0001);
      chk(irq, 0);
      wr(dtrig_pkg::DTRIG_REG_CTRL, 32'h0000_0010);
      eq.fall(3);
      chk(n_load, 1);
      chk(irq, 1);
      $display("end timer");
      print_verdict;
   end
endmodule
